/* File: logic/pls_pkg.sv */
// package: register map, reset values, timing and types of the led/strap/power-down block
// Summary of operation
// - no received signal counts as link down
// - idle for 32 s enters deep sleep
// - transmit enable low required to start countdown
// - sleep shuts only sections selected by bits 8-4
// - five status pins set by register 20
// - each pin shows link, activity, tx, rx, col, speed, duplex
// - pins are inputs in reset, latched, then outputs
// - software reset leaves pin direction and straps alone
// - asserted output level is inverse of latched strap
// - management map 0-31 with reserved 9-15
package pls_pkg;
    // =============================================================
    // register indices, byte address is four times the index
    localparam int REG_IDX_W = 5;
    localparam logic [4:0] IDX_CTRL = 5'h00;
    localparam logic [4:0] IDX_STATUS = 5'h01;
    localparam logic [4:0] IDX_ID_HI = 5'h02;
    localparam logic [4:0] IDX_ID_LO = 5'h03;
    localparam logic [4:0] IDX_AN_FIRST = 5'h04;
    localparam logic [4:0] IDX_AN_LAST = 5'h08;
    localparam logic [4:0] IDX_RSV_FIRST = 5'h09;
    localparam logic [4:0] IDX_RSV_LAST = 5'h0F;
    localparam logic [4:0] IDX_LED_CFG = 5'h14;
    localparam logic [4:0] IDX_PD_SEL = 5'h18;
    localparam logic [4:0] IDX_PD_STAT = 5'h19;
    localparam logic [4:0] IDX_STRAP = 5'h1A;
    // =============================================================
    // reset values and field positions
    localparam logic [15:0] CTRL_RESET = 16'h3100;
    localparam logic [15:0] AN_ADV_RESET = 16'h01E1;
    localparam logic [15:0] LED_CFG_RESET = 16'h4D48;
    localparam logic [15:0] PD_SEL_RESET = 16'h01F0;
    localparam logic [15:0] STATUS_BASE = 16'h7809;
    localparam int CTRL_SOFT_RST_BIT = 15;
    localparam int STATUS_LINK_BIT = 2;
    localparam int PD_SEL_LSB = 4;
    localparam int NUM_PINS = 5;
    localparam int LED_FIELD_W = 3;
    localparam int AN_REGS = 5;
    // =============================================================
    // timing: one ms tick, then 32 s of ticks
    localparam int CLK_PERIOD_NS = 10;
    localparam int TICK_TIME_NS = 1000000;
    localparam int TICK_CYCLES = TICK_TIME_NS / CLK_PERIOD_NS;
    localparam int SLEEP_TIME_S = 32;
    localparam int TICKS_PER_S = 1000;
    localparam int SLEEP_TICKS = SLEEP_TIME_S * TICKS_PER_S;
    localparam int TICK_CNT_W = 17;
    localparam int SLEEP_CNT_W = 16;
    // =============================================================
    // bus
    localparam int AXI_ADDR_W = 8;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // =============================================================
    // types
    typedef enum logic [2:0] {
        LED_LINK = 3'h0, LED_ACT = 3'h1, LED_TX = 3'h2, LED_RX = 3'h3,
        LED_COL = 3'h4, LED_SPEED = 3'h5, LED_DUPLEX = 3'h6, LED_OFF = 3'h7
    } pls_led_sel_type;
    typedef enum logic [1:0] {
        PD_AWAKE = 2'h0, PD_COUNT = 2'h1, PD_SLEEP = 2'h3
    } pls_pd_state_type;
endpackage

/* File: logic/pls_reg_if.sv */
// interface: register access between bus slave and register file
`timescale 1ns/1ps
interface pls_reg_if;
    logic wr_en;
    logic [4:0] wr_idx;
    logic [15:0] wr_data;
    logic [1:0] wr_strb;
    logic [4:0] rd_idx;
    logic [15:0] rd_data;
    modport bus (output wr_en, wr_idx, wr_data, wr_strb, rd_idx, input rd_data);
    modport regs (input wr_en, wr_idx, wr_data, wr_strb, rd_idx, output rd_data);
endinterface

/* File: logic/pls_axil.sv */
// module: axi4-lite slave front end of the register file
`timescale 1ns/1ps
module pls_axil
    import pls_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // write channels
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // read channels
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // register side
    pls_reg_if.bus regs
);
    // =============================================================
    // write: address and data taken together, one response open
    logic wr_fire;
    logic rd_fire;
    assign awready = awvalid && wvalid && !bvalid;
    assign wready = awready;
    assign wr_fire = awready;
    // only the lower 32 words exist, the upper half answers slverr
    assign regs.wr_en = wr_fire && !awaddr[7];
    assign regs.wr_idx = awaddr[6:2];
    assign regs.wr_data = wdata[15:0];
    assign regs.wr_strb = wstrb[1:0];

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
        end else if (wr_fire) begin
            bvalid <= 1'b1;
            bresp <= awaddr[7] ? RESP_SLVERR : RESP_OKAY;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end
    // =============================================================
    // read: one outstanding, data captured at acceptance
    assign arready = !rvalid;
    assign rd_fire = arvalid && arready;
    assign regs.rd_idx = araddr[6:2];

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rvalid <= 1'b0;
            rdata <= 32'h00000000;
            rresp <= RESP_OKAY;
        end else if (rd_fire) begin
            rvalid <= 1'b1;
            rdata <= araddr[7] ? 32'h00000000 : {16'h0000, regs.rd_data};
            rresp <= araddr[7] ? RESP_SLVERR : RESP_OKAY;
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

    bresp_hold_a: assert property (@(posedge clk) disable iff (reset)
        bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped before bready");
    read_err_a: assert property (@(posedge clk) disable iff (reset)
        rd_fire && araddr[7] |=> rvalid && rresp == RESP_SLVERR && rdata == 32'h00000000)
        else $error("unmapped read not answered with slverr");
endmodule

/* File: logic/pls_strap_pin.sv */
// module: one strap pin that turns into an inverted-polarity led driver
`timescale 1ns/1ps
module pls_strap_pin (
    // clock and hardware reset only, soft reset never reaches here
    input wire logic clk,
    input wire logic reset,
    // pin and status
    input wire logic pin_in,
    input wire logic led_on,
    output logic pin_out,
    output logic pin_oe_n,
    output logic strap
);
    // =============================================================
    // capture once after release, drive one cycle later
    logic latched;
    logic drive;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            latched <= 1'b0;
            strap <= 1'b0;
        end else if (!latched) begin
            latched <= 1'b1;
            strap <= pin_in;
        end
    end
    // the extra stage keeps the pin floating until the strap is known
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            drive <= 1'b0;
        end else begin
            drive <= latched;
        end
    end
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pin_out <= 1'b0;
        end else begin
            pin_out <= led_on ^ strap;
        end
    end
    assign pin_oe_n = !drive;

    led_invert_a: assert property (@(posedge clk) disable iff (reset)
        latched && $past(latched) |-> pin_out == ($past(led_on) ^ strap))
        else $error("led level not inverse of strap");
    strap_hold_a: assert property (@(posedge clk) disable iff (reset)
        latched |=> latched && $stable(strap) ##1 !pin_oe_n)
        else $error("strap or direction changed after capture");
endmodule

/* File: logic/pls_top.sv */
// module: top of the led/strap and deep power-down block with its registers
`timescale 1ns/1ps
module pls_top
    import pls_pkg::*;
#(
    parameter int TICK_LEN = TICK_CYCLES,
    parameter int SLEEP_LEN = SLEEP_TICKS,
    // identifier values are arbitrary
    parameter logic [15:0] ID_HI = 16'hA5A5,
    parameter logic [15:0] ID_LO = 16'h5A50
) (
    // clock and reset
    input wire logic CLK_SYS,
    input wire logic RESET,
    // axi4-lite write
    input wire logic [7:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    // axi4-lite read
    input wire logic [7:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    // phy status and mac transmit enable
    input wire logic RX_SIGNAL,
    input wire logic TX_EN,
    input wire logic LINK_UP,
    input wire logic TX_ACTIVE,
    input wire logic RX_ACTIVE,
    input wire logic COLLISION,
    input wire logic SPEED_100,
    input wire logic FULL_DUPLEX,
    // strap/led pins, bit 0 is pin a up to bit 4 pin e
    input wire logic [4:0] STRAP_LED_PIN_IN,
    output logic [4:0] STRAP_LED_PIN_OUT,
    output logic [4:0] STRAP_LED_PIN_OE_N,
    // power control and strap results
    output logic DEEP_SLEEP_STATE,
    output logic [4:0] SECTION_OFF,
    output logic SOFT_RESET,
    output logic [1:0] MGMT_ADDR_STRAP
);
    // =============================================================
    // helpers
    function automatic logic pick_led(input logic [2:0] sel, input logic [7:0] vec);
        pick_led = vec[sel];
    endfunction

    function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] d,
                                          input logic [1:0] strb);
        merge = old;
        if (strb[0]) begin
            merge[7:0] = d[7:0];
        end
        if (strb[1]) begin
            merge[15:8] = d[15:8];
        end
    endfunction

    // =============================================================
    // bus slave
    pls_reg_if rif ();

    pls_axil u_axil (
        .clk(CLK_SYS),
        .reset(RESET),
        .awaddr(S_AXI_AWADDR),
        .awvalid(S_AXI_AWVALID),
        .awready(S_AXI_AWREADY),
        .wdata(S_AXI_WDATA),
        .wstrb(S_AXI_WSTRB),
        .wvalid(S_AXI_WVALID),
        .wready(S_AXI_WREADY),
        .bresp(S_AXI_BRESP),
        .bvalid(S_AXI_BVALID),
        .bready(S_AXI_BREADY),
        .araddr(S_AXI_ARADDR),
        .arvalid(S_AXI_ARVALID),
        .arready(S_AXI_ARREADY),
        .rdata(S_AXI_RDATA),
        .rresp(S_AXI_RRESP),
        .rvalid(S_AXI_RVALID),
        .rready(S_AXI_RREADY),
        .regs(rif.bus)
    );

    // =============================================================
    // register file
    logic [15:0] ctrl;
    logic [15:0] an_reg [AN_REGS];
    logic [15:0] led_cfg;
    logic [15:0] pd_sel;
    logic soft_rst;
    logic [4:0] strap;
    pls_pd_state_type pd_state;
    pls_pd_state_type next_state;
    logic wr_ctrl;

    assign wr_ctrl = rif.wr_en && rif.wr_idx == IDX_CTRL;

    // self-clearing reset bit, it is never stored
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            soft_rst <= 1'b0;
        end else begin
            soft_rst <= wr_ctrl && rif.wr_strb[1] && rif.wr_data[CTRL_SOFT_RST_BIT];
        end
    end
    assign SOFT_RESET = soft_rst;

    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            ctrl <= CTRL_RESET;
        end else if (soft_rst) begin
            ctrl <= CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl <= merge(ctrl, rif.wr_data, rif.wr_strb) & 16'h7F80;
        end
    end

    genvar g;
    generate
        for (g = 0; g < AN_REGS; g++) begin : g_an
            always_ff @(posedge CLK_SYS or posedge RESET) begin
                if (RESET) begin
                    an_reg[g] <= (g == 0) ? AN_ADV_RESET : 16'h0000;
                end else if (soft_rst) begin
                    an_reg[g] <= (g == 0) ? AN_ADV_RESET : 16'h0000;
                end else if (rif.wr_en && rif.wr_idx == IDX_AN_FIRST + 5'(g)) begin
                    an_reg[g] <= merge(an_reg[g], rif.wr_data, rif.wr_strb);
                end
            end
        end
    endgenerate

    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            led_cfg <= LED_CFG_RESET;
        end else if (soft_rst) begin
            led_cfg <= LED_CFG_RESET;
        end else if (rif.wr_en && rif.wr_idx == IDX_LED_CFG) begin
            led_cfg <= merge(led_cfg, rif.wr_data, rif.wr_strb) & 16'h7FFF;
        end
    end

    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            pd_sel <= PD_SEL_RESET;
        end else if (soft_rst) begin
            pd_sel <= PD_SEL_RESET;
        end else if (rif.wr_en && rif.wr_idx == IDX_PD_SEL) begin
            pd_sel <= merge(pd_sel, rif.wr_data, rif.wr_strb) & 16'h01F0;
        end
    end

    // reserved words and unlisted vendor words read as zero
    always_comb begin
        rif.rd_data = 16'h0000;
        if (rif.rd_idx == IDX_CTRL) begin
            rif.rd_data = ctrl;
        end else if (rif.rd_idx == IDX_STATUS) begin
            rif.rd_data = STATUS_BASE;
            rif.rd_data[STATUS_LINK_BIT] = LINK_UP;
        end else if (rif.rd_idx == IDX_ID_HI) begin
            rif.rd_data = ID_HI;
        end else if (rif.rd_idx == IDX_ID_LO) begin
            rif.rd_data = ID_LO;
        end else if (rif.rd_idx >= IDX_AN_FIRST && rif.rd_idx <= IDX_AN_LAST) begin
            rif.rd_data = an_reg[3'(rif.rd_idx - IDX_AN_FIRST)];
        end else if (rif.rd_idx == IDX_LED_CFG) begin
            rif.rd_data = led_cfg;
        end else if (rif.rd_idx == IDX_PD_SEL) begin
            rif.rd_data = pd_sel;
        end else if (rif.rd_idx == IDX_PD_STAT) begin
            rif.rd_data = {14'h0000, pd_state == PD_SLEEP, pd_state == PD_COUNT};
        end else if (rif.rd_idx == IDX_STRAP) begin
            rif.rd_data = {11'h000, strap};
        end
    end

    // =============================================================
    // deep power-down timer
    logic idle_cond;
    logic [TICK_CNT_W-1:0] tick_cnt;
    logic tick;
    logic [SLEEP_CNT_W-1:0] sleep_cnt;
    logic last_tick;

    // no line signal and no transmit from the mac
    assign idle_cond = !RX_SIGNAL && !TX_EN;
    assign last_tick = tick && sleep_cnt == SLEEP_CNT_W'(SLEEP_LEN - 1);

    // the divider only runs while counting, so each countdown starts clean
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            tick_cnt <= '0;
            tick <= 1'b0;
        end else if (pd_state != PD_COUNT || !idle_cond) begin
            tick_cnt <= '0;
            tick <= 1'b0;
        end else if (tick_cnt == TICK_CNT_W'(TICK_LEN - 1)) begin
            tick_cnt <= '0;
            tick <= 1'b1;
        end else begin
            tick_cnt <= tick_cnt + 1'b1;
            tick <= 1'b0;
        end
    end

    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            sleep_cnt <= '0;
        end else if (pd_state != PD_COUNT || !idle_cond) begin
            sleep_cnt <= '0;
        end else if (tick) begin
            sleep_cnt <= sleep_cnt + 1'b1;
        end
    end

    always_comb begin
        next_state = pd_state;
        case (pd_state)
            PD_AWAKE: begin
                if (idle_cond) begin
                    next_state = PD_COUNT;
                end
            end
            PD_COUNT: begin
                if (!idle_cond) begin
                    next_state = PD_AWAKE;
                end else if (last_tick) begin
                    next_state = PD_SLEEP;
                end
            end
            PD_SLEEP: begin
                if (!idle_cond) begin
                    next_state = PD_AWAKE;
                end
            end
            default: begin
                next_state = PD_AWAKE;
            end
        endcase
    end

    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            pd_state <= PD_AWAKE;
        end else if (soft_rst) begin
            pd_state <= PD_AWAKE;
        end else begin
            pd_state <= next_state;
        end
    end

    // only the selected sections go dark while asleep
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            DEEP_SLEEP_STATE <= 1'b0;
            SECTION_OFF <= 5'h00;
        end else if (soft_rst) begin
            DEEP_SLEEP_STATE <= 1'b0;
            SECTION_OFF <= 5'h00;
        end else begin
            DEEP_SLEEP_STATE <= next_state == PD_SLEEP;
            SECTION_OFF <= (next_state == PD_SLEEP) ?
                pd_sel[PD_SEL_LSB +: NUM_PINS] : 5'h00;
        end
    end

    // =============================================================
    // strap pins and led drivers
    logic [7:0] status_vec;
    logic [4:0] led_on;

    assign status_vec = {1'b0, FULL_DUPLEX, SPEED_100, COLLISION,
                         RX_ACTIVE, TX_ACTIVE, TX_ACTIVE || RX_ACTIVE, LINK_UP};

    generate
        for (g = 0; g < NUM_PINS; g++) begin : g_pin
            assign led_on[g] = pick_led(led_cfg[g*LED_FIELD_W +: LED_FIELD_W],
                                        status_vec);
            pls_strap_pin u_pin (
                .clk(CLK_SYS),
                .reset(RESET),
                .pin_in(STRAP_LED_PIN_IN[g]),
                .led_on(led_on[g]),
                .pin_out(STRAP_LED_PIN_OUT[g]),
                .pin_oe_n(STRAP_LED_PIN_OE_N[g]),
                .strap(strap[g])
            );
        end
    endgenerate

    // board resistors on pins a and b give the low address bits
    assign MGMT_ADDR_STRAP = strap[1:0];

    // =============================================================
    // checks
    count_start_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
        pd_state == PD_AWAKE && idle_cond && !soft_rst |=> pd_state == PD_COUNT)
        else $error("countdown did not start when idle");
    no_start_tx_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
        pd_state == PD_AWAKE && (TX_EN || RX_SIGNAL) |=> pd_state == PD_AWAKE)
        else $error("countdown started while not idle");
    sleep_entry_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
        pd_state == PD_COUNT && idle_cond && last_tick && !soft_rst
        |=> pd_state == PD_SLEEP && DEEP_SLEEP_STATE)
        else $error("deep sleep not entered after full count");
    early_sleep_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
        $rose(pd_state == PD_SLEEP) |-> $past(last_tick))
        else $error("deep sleep entered before count ended");
    wake_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
        pd_state != PD_AWAKE && !idle_cond |=> pd_state == PD_AWAKE ##0 SECTION_OFF == 5'h00)
        else $error("activity did not abort or wake");
    sections_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
        pd_state == PD_SLEEP && $past(pd_state == PD_SLEEP) && $stable(pd_sel)
        |-> SECTION_OFF == pd_sel[8:4] && DEEP_SLEEP_STATE)
        else $error("wrong sections off in deep sleep");
    led_pick_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
        !STRAP_LED_PIN_OE_N[0] && $stable(led_cfg)
        |=> STRAP_LED_PIN_OUT[0] == ($past(status_vec[led_cfg[2:0]]) ^ strap[0]))
        else $error("pin a does not follow selected status");
    soft_pins_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
        soft_rst && STRAP_LED_PIN_OE_N == 5'h00 |=> STRAP_LED_PIN_OE_N == 5'h00 && $stable(strap))
        else $error("software reset disturbed pins");
    map_rsv_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
        S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR[7:2] >= 6'h09 && S_AXI_ARADDR[7:2] <= 6'h0F
        |=> S_AXI_RDATA == 32'h00000000)
        else $error("reserved register read nonzero");

    sleep_c: cover property (@(posedge CLK_SYS) disable iff (RESET) $rose(DEEP_SLEEP_STATE));
    abort_c: cover property (@(posedge CLK_SYS) disable iff (RESET)
        pd_state == PD_COUNT && TX_EN);
    soft_c: cover property (@(posedge CLK_SYS) disable iff (RESET) soft_rst);
    led_c: cover property (@(posedge CLK_SYS) disable iff (RESET)
        !STRAP_LED_PIN_OE_N[1] && led_on[1]);
endmodule

/* File: tb/pls_far_model.sv */
// partner model: mac transmit enable, received signal and strap resistors
`timescale 1ns/1ps
module pls_far_model (
    // clock and test requests
    input wire logic clk,
    input wire logic tx_req,
    input wire logic rx_req,
    input wire logic [4:0] strap_level,
    // pins
    input wire logic [4:0] pin_out,
    input wire logic [4:0] pin_oe_n,
    output logic [4:0] pin_in,
    output logic rx_signal,
    output logic tx_en
);
    // =============================================================
    // resistors set the level only while the pin is released
    assign pin_in = (pin_oe_n & strap_level) | (~pin_oe_n & pin_out);
    // mac moves its levels right after the edge, as a synchronous source
    initial begin
        rx_signal = 1'b1;
        tx_en = 1'b0;
    end
    always @(posedge clk) begin
        rx_signal <= rx_req;
        tx_en <= tx_req;
    end
endmodule

/* File: tb/pls_top_tb_top.sv */
// testbench: registers, straps, led polarity and deep sleep timing
`timescale 1ns/1ps
module pls_top_tb_top;
    import pls_pkg::*;
    logic clk = 1'b0, rst = 1'b1, awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
    logic [7:0] awa = 8'h00, ara = 8'h00;
    logic [31:0] wd = 32'h0, v;
    logic [3:0] ws = 4'h3;
    logic tx_req = 1'b0, rx_req = 1'b1;
    logic [5:0] src = 6'h3F;
    logic [5:0] pat [3] = '{6'h15, 6'h2A, 6'h3F};
    logic [4:0] strap = 5'h0D;
    logic [1:0] r;
    wire awr, wr, bv, arr, rv, rxs, txe, dss, srst;
    wire [1:0] brs, rrs, mga;
    wire [31:0] rd;
    wire [4:0] pin_in, pout, poe_n, soff;
    int n_fail = 0, comparisons = 0, i;
    logic [7:0] ra [8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h24, 8'h50, 8'h60, 8'h80};
    logic [33:0] rx [8] = '{34'(CTRL_RESET), 34'h780D, 34'hA5A5, 34'h5A50, 34'h0,
        34'(LED_CFG_RESET), 34'(PD_SEL_RESET), {RESP_SLVERR, 32'h0}};
    initial begin
        forever #5 clk = ~clk;
    end
    pls_far_model far (.clk(clk), .tx_req(tx_req), .rx_req(rx_req), .strap_level(strap),
        .pin_out(pout), .pin_oe_n(poe_n), .pin_in(pin_in), .rx_signal(rxs), .tx_en(txe));
    pls_top #(.TICK_LEN(4), .SLEEP_LEN(3)) dut (.CLK_SYS(clk), .RESET(rst),
        .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd),
        .S_AXI_WSTRB(ws), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr), .S_AXI_BRESP(brs),
        .S_AXI_BVALID(bv), .S_AXI_BREADY(br), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv),
        .S_AXI_ARREADY(arr), .S_AXI_RDATA(rd), .S_AXI_RRESP(rrs), .S_AXI_RVALID(rv),
        .S_AXI_RREADY(rr), .RX_SIGNAL(rxs), .TX_EN(txe), .LINK_UP(src[0]),
        .TX_ACTIVE(src[1]), .RX_ACTIVE(src[2]), .COLLISION(src[3]), .SPEED_100(src[4]),
        .FULL_DUPLEX(src[5]), .STRAP_LED_PIN_IN(pin_in), .STRAP_LED_PIN_OUT(pout),
        .STRAP_LED_PIN_OE_N(poe_n), .DEEP_SLEEP_STATE(dss), .SECTION_OFF(soff),
        .SOFT_RESET(srst), .MGMT_ADDR_STRAP(mga));
    // =============================================================
    // tasks
    task automatic print_verdict();
        $display("counts: %0d compared, %0d mismatched", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [33:0] seen, input logic [33:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // expected lamp state for a select code and a set of status sources
    function automatic logic lit(input int c, input logic [5:0] s);
        case (c)
            0: lit = s[0];
            1: lit = s[1] | s[2];
            2: lit = s[1];
            3: lit = s[2];
            4: lit = s[3];
            5: lit = s[4];
            6: lit = s[5];
            default: lit = 1'b0;
        endcase
    endfunction
    task automatic tmo();
        if (i >= 60) begin
            n_fail++;
            print_verdict();
        end
    endtask
    // waits start in the edge's active region, before the slave's own updates land
    task automatic axi_wr(input logic [7:0] a, input logic [15:0] d, input logic [3:0] s);
        @(posedge clk);
        awa <= a;
        wd <= {16'h0000, d};
        ws <= s;
        awv <= 1'b1;
        wv <= 1'b1;
        br <= 1'b1;
        for (i = 0; i < 60 && !(awr && wr); i++) @(negedge clk);
        tmo();
        @(posedge clk);
        awv <= 1'b0;
        wv <= 1'b0;
        for (i = 0; i < 60 && !bv; i++) @(negedge clk);
        tmo();
        @(posedge clk);
        r = brs;
        br <= 1'b0;
    endtask
    task automatic axi_rd(input logic [7:0] a);
        @(posedge clk);
        ara <= a;
        arv <= 1'b1;
        rr <= 1'b1;
        for (i = 0; i < 60 && !arr; i++) @(negedge clk);
        tmo();
        @(posedge clk);
        arv <= 1'b0;
        for (i = 0; i < 60 && !rv; i++) @(negedge clk);
        tmo();
        @(posedge clk);
        v = rd;
        r = rrs;
        rr <= 1'b0;
    endtask
    // =============================================================
    // main sequence
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(negedge clk);
        chk("pins", {poe_n, mga}, {5'h00, strap[1:0]});
        foreach (ra[k]) begin
            axi_rd(ra[k]);
            chk("read", {r, v}, rx[k]);
        end
        axi_wr(8'h80, 16'hFFFF, 4'h3);
        chk("bresp", r, RESP_SLVERR);
        $display("test map done");
        for (int c = 0; c < 8; c++) begin
            axi_wr(8'h50, 16'h7FC0 | 16'(c) | (16'(c) << 3), 4'h3);
            // sources alternate per pattern so a select one code off shows up
            foreach (pat[p]) begin
                @(posedge clk);
                src <= pat[p];
                repeat (3) @(negedge clk);
                chk("leds", pout, {strap[4:2], strap[1:0] ^ {2{lit(c, pat[p])}}});
            end
        end
        $display("test leds done");
        axi_wr(8'h60, 16'h0150, 4'h3);
        rx_req <= 1'b0;
        repeat (6) @(posedge clk);
        tx_req <= 1'b1;
        @(posedge clk);
        tx_req <= 1'b0;
        for (i = 0; i < 60 && !dss; i++) @(posedge clk);
        tmo();
        chk("delay", i >= 12 && i < 40, 1);
        chk("sections", soff, 5'h15);
        rx_req <= 1'b1;
        for (i = 0; i < 60 && dss; i++) @(posedge clk);
        tmo();
        chk("wake", {i < 5, soff}, {1'b1, 5'h00});
        $display("test sleep done");
        axi_wr(8'h00, 16'h8000, 4'h2);
        chk("soft_bit", srst, 1);
        repeat (3) @(negedge clk);
        chk("soft", {poe_n, mga}, {5'h00, strap[1:0]});
        axi_rd(8'h50);
        chk("led_cfg", {r, v}, LED_CFG_RESET);
        $display("test soft reset done");
        print_verdict();
    end
endmodule
